// ===== cfg_pkg.sv
package cfg_pkg;
  // register pointer values
  localparam logic [7:0] ADDR_FAULT_MASK = 8'h11;
  localparam logic [7:0] ADDR_CONVERTER_TUNING = 8'h12;
  localparam logic [7:0] ADDR_OUTPUT_REFERENCE = 8'h13;
  // reset values
  localparam logic [4:0] FAULT_MASK_RESET = 5'h0F;
  localparam logic [2:0] COMP_RESET = 3'h2;
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam logic [2:0] LIMIT_RESET = 3'h0;
  localparam logic [7:0] REF_RESET = 8'h44;
  // field widths and positions
  localparam int MASK_WIDTH = 5;
  localparam int PG_BIT = 4;
  localparam int FAULT_COUNT = 4;
  localparam int COMP_LSB = 5;
  localparam int RATE_LSB = 3;
  localparam int LIMIT_LSB = 0;
  // reference clamp limits
  localparam logic [7:0] REF_CODE_MIN = 8'h3D;
  localparam logic [7:0] REF_CODE_MAX = 8'hCC;
  localparam logic [2:0] ZERO3 = 3'h0;
endpackage

// ===== ref_clamp.sv
`timescale 1ns/10ps
module ref_clamp
  import cfg_pkg::*;
(
  input wire logic [7:0] code,
  output logic [7:0] clamped
);
  // codes below the linear range pin to the floor, above it to the ceiling
  always_comb begin
    if (code < REF_CODE_MIN) begin
      clamped = REF_CODE_MIN;
    end else if (code > REF_CODE_MAX) begin
      clamped = REF_CODE_MAX;
    end else begin
      clamped = code;
    end
  end
endmodule

// ===== fault_gate.sv
`timescale 1ns/10ps
module fault_gate
  import cfg_pkg::*;
(
  input wire logic [FAULT_COUNT-1:0] source,
  input wire logic [FAULT_COUNT-1:0] mask,
  output logic [FAULT_COUNT-1:0] pass
);
  // one gate per fault source
  for (genvar i = 0; i < FAULT_COUNT; i++) begin : g_src
    assign pass[i] = source[i] & ~mask[i];
  end
endmodule

// ===== converter_config_mask_regs.sv
`timescale 1ns/10ps
module converter_config_mask_regs
  import cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic shutdown,
  input wire logic io_supply_ok,
  input wire logic input_uvlo,
  input wire logic enable,
  input wire logic [7:0] reg_ptr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic [FAULT_COUNT-1:0] fault_source,
  input wire logic power_good,
  output logic [FAULT_COUNT-1:0] fault_irq,
  output logic power_good_out,
  output logic [2:0] comp_sel,
  output logic [1:0] switching_rate_sel,
  output logic [2:0] current_limit_sel,
  output logic [7:0] reference_code
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and reset causes
  logic [MASK_WIDTH-1:0] mask_q, mask_d;
  logic [7:0] tune_q, tune_d;
  logic [7:0] ref_q, ref_d;
  logic [7:0] rd_data_d;
  logic rd_valid_d;
  logic [FAULT_COUNT-1:0] irq_d;
  logic pg_d;
  logic [7:0] ref_clamped;
  logic clear_all;

  // any documented shutdown cause sends every register to its default
  assign clear_all = rst | shutdown | ~io_supply_ok | input_uvlo | ~enable;

  ////////////////////////////////////////////////////////////////////////////
  // register write path
  always_comb begin
    mask_d = mask_q;
    tune_d = tune_q;
    ref_d = ref_q;
    if (clear_all) begin
      mask_d = FAULT_MASK_RESET;
      tune_d = {COMP_RESET, RATE_RESET, LIMIT_RESET};
      ref_d = REF_RESET;
    end else if (wr_en) begin
      // data lands at the location the pointer selects
      case (reg_ptr)
        ADDR_FAULT_MASK: mask_d = wr_data[MASK_WIDTH-1:0];
        ADDR_CONVERTER_TUNING: tune_d = wr_data;
        ADDR_OUTPUT_REFERENCE: ref_d = wr_data;
        default: mask_d = mask_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; reserved and unmapped locations give zero
  always_comb begin
    rd_data_d = 8'h00;
    rd_valid_d = rd_en & ~clear_all;
    if (rd_en) begin
      case (reg_ptr)
        ADDR_FAULT_MASK: rd_data_d = {ZERO3, mask_q};
        ADDR_CONVERTER_TUNING: rd_data_d = tune_q;
        ADDR_OUTPUT_REFERENCE: rd_data_d = ref_q;
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived outputs
  fault_gate u_gate (
    .source(fault_source),
    .mask(mask_q[FAULT_COUNT-1:0]),
    .pass(irq_d)
  );

  ref_clamp u_clamp (
    .code(ref_q),
    .clamped(ref_clamped)
  );

  // power-good is only reported while its mask bit is clear
  assign pg_d = power_good & ~mask_q[PG_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk) begin
    mask_q <= mask_d;
    tune_q <= tune_d;
    ref_q <= ref_d;
    if (rst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      fault_irq <= '0;
      power_good_out <= 1'b0;
      comp_sel <= COMP_RESET;
      switching_rate_sel <= RATE_RESET;
      current_limit_sel <= LIMIT_RESET;
      reference_code <= REF_RESET;
    end else begin
      rd_data <= rd_data_d;
      rd_valid <= rd_valid_d;
      fault_irq <= irq_d;
      power_good_out <= pg_d;
      comp_sel <= tune_q[COMP_LSB+2:COMP_LSB];
      switching_rate_sel <= tune_q[RATE_LSB+1:RATE_LSB];
      current_limit_sel <= tune_q[LIMIT_LSB+2:LIMIT_LSB];
      reference_code <= ref_clamped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_FAULT_RESET: assert property (@(posedge clk)
    clear_all |=> mask_q == FAULT_MASK_RESET)
    else $error("mask not defaulted");
  AST_TUNE_RESET: assert property (@(posedge clk)
    clear_all |=> tune_q == {COMP_RESET, RATE_RESET, LIMIT_RESET})
    else $error("tuning not defaulted");
  AST_REF_RESET: assert property (@(posedge clk)
    clear_all |=> ref_q == REF_RESET)
    else $error("reference not defaulted");
  AST_SHUTDOWN: assert property (@(posedge clk) disable iff (rst)
    (shutdown || !enable) |=> ##1 reference_code == REF_RESET)
    else $error("shutdown did not reset");
  AST_MASK_GATE: assert property (@(posedge clk) disable iff (rst)
    ##1 fault_irq == ($past(fault_source) & ~$past(mask_q[FAULT_COUNT-1:0])))
    else $error("fault gating wrong");
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (rst)
    (rd_en && reg_ptr == ADDR_FAULT_MASK) |=> rd_data[7:5] == ZERO3)
    else $error("reserved bits nonzero");
  AST_LOW_CLAMP: assert property (@(posedge clk) disable iff (clear_all)
    ref_q < REF_CODE_MIN |=> reference_code == REF_CODE_MIN)
    else $error("low clamp wrong");
  AST_HIGH_CLAMP: assert property (@(posedge clk) disable iff (clear_all)
    ref_q > REF_CODE_MAX |=> reference_code == REF_CODE_MAX)
    else $error("high clamp wrong");
  // a tuning write, one cycle with no write strobe, then a read of the same location
  AST_WRITE_READ: assert property (@(posedge clk) disable iff (clear_all)
    (wr_en && reg_ptr == ADDR_CONVERTER_TUNING && !rd_en) ##1 (!wr_en) ##1 (rd_en && !wr_en
    && reg_ptr == ADDR_CONVERTER_TUNING) |=> rd_data == $past(wr_data, 3))
    else $error("readback mismatch");
  AST_PG_MASK: assert property (@(posedge clk) disable iff (rst)
    mask_q[PG_BIT] |=> !power_good_out)
    else $error("power-good leaked");

  COV_WRITE_MASK: cover property (@(posedge clk) wr_en && reg_ptr == ADDR_FAULT_MASK);
  COV_IRQ: cover property (@(posedge clk) |fault_irq);
  COV_CLAMP: cover property (@(posedge clk) ref_q > REF_CODE_MAX);
  COV_SHUT: cover property (@(posedge clk) !rst && shutdown);
endmodule

// ===== reg_host.sv
`timescale 1ns/10ps
// host side of the register port
module reg_host (
  input wire logic clk,
  output logic [7:0] reg_ptr,
  output logic wr_en,
  output logic [7:0] wr_data,
  output logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  logic [7:0] got;
  // idle bus at time zero
  initial begin
    {reg_ptr, wr_en, wr_data, rd_en} = 18'h00000;
  end
  // one byte access, pointer given with it
  task automatic acc(input logic w, input logic [7:0] p, input logic [7:0] d);
    @(posedge clk) #1;
    reg_ptr = p;
    wr_data = d;
    wr_en = w;
    rd_en = !w;
    @(posedge clk) #1;
    got = rd_valid ? rd_data : 8'hEE;
    {wr_en, rd_en} = 2'h0;
    reg_ptr = ~p; // released lines do not keep the last value
    wr_data = ~d;
  endtask
endmodule

// ===== converter_config_mask_regs_bench.sv
`timescale 1ns/10ps
module converter_config_mask_regs_bench import cfg_pkg::*;;
  logic clk = 0;
  logic rst = 1;
  logic [3:0] cause = 4'h0;
  logic [3:0] fault_source = 4'h0;
  logic power_good = 0;
  logic [7:0] reg_ptr, wr_data, rd_data, reference_code;
  logic wr_en, rd_en, rd_valid, power_good_out;
  logic [3:0] fault_irq;
  logic [2:0] comp_sel, current_limit_sel;
  logic [1:0] switching_rate_sel;
  int mismatches = 0;
  int tests_run = 0;
  always #25 clk = ~clk;
  converter_config_mask_regs converter_config_mask_regs_i (.clk(clk), .rst(rst),
    .shutdown(cause[0]), .io_supply_ok(!cause[1]), .input_uvlo(cause[2]),
    .enable(!cause[3]), .reg_ptr(reg_ptr), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .fault_source(fault_source), .power_good(power_good), .fault_irq(fault_irq),
    .power_good_out(power_good_out), .comp_sel(comp_sel),
    .switching_rate_sel(switching_rate_sel), .current_limit_sel(current_limit_sel),
    .reference_code(reference_code));
  reg_host reg_host_i (.clk(clk), .reg_ptr(reg_ptr), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid));
  ////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    reg_host_i.acc(1'b0, p, 8'h00);
    chk(reg_host_i.got, exp);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_defaults;
    rd(ADDR_FAULT_MASK, 8'h0F);
    rd(ADDR_CONVERTER_TUNING, 8'h50);
    rd(ADDR_OUTPUT_REFERENCE, 8'h44);
    rd(8'h10, 8'h00);
    chk({comp_sel, switching_rate_sel, current_limit_sel}, 8'h50);
  endtask
  task automatic t_mask;
    fault_source = 4'hF;
    power_good = 1;
    reg_host_i.acc(1'b1, ADDR_FAULT_MASK, 8'hFF);
    rd(ADDR_FAULT_MASK, 8'h1F);
    chk({3'h0, power_good_out, fault_irq}, 8'h00);
    reg_host_i.acc(1'b1, ADDR_FAULT_MASK, 8'h05);
    fault_source = 4'h6;
    step(2);
    chk({3'h0, power_good_out, fault_irq}, 8'h12);
  endtask
  task automatic t_tuning;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], i[1:0], ~i[2:0]};
      reg_host_i.acc(1'b1, ADDR_CONVERTER_TUNING, v);
      rd(ADDR_CONVERTER_TUNING, v);
      step(1);
      chk({comp_sel, switching_rate_sel, current_limit_sel}, v);
    end
  endtask
  task automatic t_ref;
    logic [7:0] c [7] = '{8'h00, 8'h3C, 8'h3D, 8'h80, 8'hCC, 8'hCD, 8'hFF};
    for (int i = 0; i < 7; i++) begin
      reg_host_i.acc(1'b1, ADDR_OUTPUT_REFERENCE, c[i]);
      step(1);
      chk(reference_code, c[i] < 8'h3D ? 8'h3D : (c[i] > 8'hCC ? 8'hCC : c[i]));
      rd(ADDR_OUTPUT_REFERENCE, c[i]);
    end
  endtask
  task automatic t_causes;
    for (int i = 0; i < 5; i++) begin
      reg_host_i.acc(1'b1, ADDR_OUTPUT_REFERENCE, 8'h99);
      reg_host_i.acc(1'b1, ADDR_FAULT_MASK, 8'h00);
      {rst, cause} = 5'h01 << i;
      reg_host_i.acc(1'b1, ADDR_FAULT_MASK, 8'h00);
      {rst, cause} = 5'h00;
      rd(ADDR_OUTPUT_REFERENCE, 8'h44);
      rd(ADDR_FAULT_MASK, 8'h0F);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 0;
    t_defaults();
    t_mask();
    t_tuning();
    t_ref();
    t_causes();
    stop_test();
  end
  // watchdog
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule
